// >>> core/counter_load_control_interface.sv
// per-channel load control interface: load slots, selectors, enables
// assumes the controller writes the cyclic output image one byte per
// i_wr_en pulse, synchronous to i_mclk; i_image_commit marks a new cycle
`timescale 1ns/1ps
module counter_load_control_interface
   import ld_ctrl_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_wr_en,
   input wire logic [3:0] i_wr_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_image_commit,
   input wire logic i_incr_encoder,
   input wire logic i_fault_clear,
   output logic o_capture_enable,
   output logic o_sync_downward_enable,
   output logic o_sync_upward_enable,
   output logic o_count_load,
   output logic [31:0] o_count_load_value,
   output logic [31:0] o_start_value,
   output logic [31:0] o_compare0_value,
   output logic [31:0] o_compare1_value,
   output logic [31:0] o_limit_low_value,
   output logic [31:0] o_limit_high_value,
   output logic [7:0] o_feedback_byte12,
   output logic [7:0] o_feedback_byte13
);
   import ld_ctrl_pkg::*;

   // ==========================================
   // control image storage
   logic [7:0] image_ff [0:11];
   logic [3:0] prev_sel0_ff;
   logic [3:0] prev_sel1_ff;
   logic load_fault_flag_ff;
   logic first_load_done_toggle_ff;
   logic second_load_done_toggle_ff;
   logic capture_enable_ff;
   logic sync_downward_enable_ff;
   logic sync_upward_enable_ff;
   logic count_load_ff;
   logic [31:0] count_load_value_ff;
   logic [31:0] start_value_ff;
   logic [31:0] compare0_ff;
   logic [31:0] compare1_ff;
   logic [31:0] limit_low_ff;
   logic [31:0] limit_high_ff;

   // byte writes land in the image; the image acts only at commit
   genvar gi;
   generate
      for (gi = 0; gi < 12; gi++) begin : g_img
         always_ff @(posedge i_mclk) begin
            if (i_reset) begin
               image_ff[gi] <= BYTE_RST;
            end else if (i_wr_en && i_wr_addr == 4'(gi)) begin
               image_ff[gi] <= i_wr_data;
            end
         end
      end
   endgenerate

   // ==========================================
   // slot assembly and selector fields
   wire [31:0] first_load_value = {image_ff[OFS_FIRST_VALUE + 4'h3],
      image_ff[OFS_FIRST_VALUE + 4'h2], image_ff[OFS_FIRST_VALUE + 4'h1],
      image_ff[OFS_FIRST_VALUE]};
   wire [31:0] second_load_value = {image_ff[OFS_SECOND_VALUE + 4'h3],
      image_ff[OFS_SECOND_VALUE + 4'h2], image_ff[OFS_SECOND_VALUE + 4'h1],
      image_ff[OFS_SECOND_VALUE]};
   wire [7:0] selectors = image_ff[OFS_SELECTORS];
   wire [7:0] enables = image_ff[OFS_ENABLES];
   wire [3:0] first_value_selector = selectors[SEL0_LSB +: 4];
   wire [3:0] second_value_selector = selectors[SEL1_LSB +: 4];

   tgt_t tgt0;
   tgt_t tgt1;
   logic rsvd0;
   logic rsvd1;

   // same code set for both slots
   sel_decode u_dec0 (
      .i_sel(first_value_selector),
      .o_tgt(tgt0),
      .o_reserved(rsvd0)
   );
   sel_decode u_dec1 (
      .i_sel(second_value_selector),
      .o_tgt(tgt1),
      .o_reserved(rsvd1)
   );

   // ==========================================
   // request detection: a new non-idle selector at commit is a request
   // why edge based: a held selector would otherwise reload every cycle
   wire req0 = i_image_commit && (first_value_selector != prev_sel0_ff)
      && (first_value_selector != SEL_IDLE);
   wire req1 = i_image_commit && (second_value_selector != prev_sel1_ff)
      && (second_value_selector != SEL_IDLE);

   // encoder-only targets fail when no incremental or pulse encoder
   function automatic logic enc_only(input tgt_t t);
      enc_only = (t == TGT_COUNT) || (t == TGT_START)
         || (t == TGT_LIM_LOW) || (t == TGT_LIM_HIGH);
   endfunction

   wire bad0 = rsvd0 || (enc_only(tgt0) && !i_incr_encoder);
   wire bad1 = rsvd1 || (enc_only(tgt1) && !i_incr_encoder);
   wire ok0 = req0 && !bad0;
   wire ok1 = req1 && !bad1;
   wire fail_evt = (req0 && bad0) || (req1 && bad1);

   // ==========================================
   // per-target load strobes and values
   // slot 1 takes priority over slot 0 in the same cycle, so it wins on a shared target;
   // the user sees both acks flip but only the slot 1 value survives

   // current count value
   wire s0_count = ok0 && (tgt0 == TGT_COUNT);
   wire s1_count = ok1 && (tgt1 == TGT_COUNT);
   wire [31:0] val_count = s1_count ? second_load_value : first_load_value;

   // start value
   wire s0_start = ok0 && (tgt0 == TGT_START);
   wire s1_start = ok1 && (tgt1 == TGT_START);
   wire [31:0] val_start = s1_start ? second_load_value : first_load_value;

   // comparison value 0
   wire s0_cmp0 = ok0 && (tgt0 == TGT_CMP0);
   wire s1_cmp0 = ok1 && (tgt1 == TGT_CMP0);
   wire [31:0] val_cmp0 = s1_cmp0 ? second_load_value : first_load_value;

   // comparison value 1
   wire s0_cmp1 = ok0 && (tgt0 == TGT_CMP1);
   wire s1_cmp1 = ok1 && (tgt1 == TGT_CMP1);
   wire [31:0] val_cmp1 = s1_cmp1 ? second_load_value : first_load_value;

   // low counting limit
   wire s0_lim_low = ok0 && (tgt0 == TGT_LIM_LOW);
   wire s1_lim_low = ok1 && (tgt1 == TGT_LIM_LOW);
   wire [31:0] val_lim_low = s1_lim_low ? second_load_value : first_load_value;

   // high counting limit
   wire s0_lim_high = ok0 && (tgt0 == TGT_LIM_HIGH);
   wire s1_lim_high = ok1 && (tgt1 == TGT_LIM_HIGH);
   wire [31:0] val_lim_high = s1_lim_high ? second_load_value : first_load_value;

   // ==========================================
   // selector history
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         prev_sel0_ff <= SEL_IDLE;
         prev_sel1_ff <= SEL_IDLE;
      end else if (i_image_commit) begin
         prev_sel0_ff <= first_value_selector;
         prev_sel1_ff <= second_value_selector;
      end
   end

   // ==========================================
   // parameter loads, one short process per target

   // count value with its one-cycle load pulse for the counter core
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         count_load_ff <= 1'b0;
         count_load_value_ff <= VALUE_RST;
      end else begin
         count_load_ff <= s0_count || s1_count;
         if (s0_count || s1_count) count_load_value_ff <= val_count;
      end
   end

   // start value
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         start_value_ff <= VALUE_RST;
      end else if (s0_start || s1_start) begin
         start_value_ff <= val_start;
      end
   end

   // comparison value 0
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         compare0_ff <= VALUE_RST;
      end else if (s0_cmp0 || s1_cmp0) begin
         compare0_ff <= val_cmp0;
      end
   end

   // comparison value 1
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         compare1_ff <= VALUE_RST;
      end else if (s0_cmp1 || s1_cmp1) begin
         compare1_ff <= val_cmp1;
      end
   end

   // low counting limit; reset value is the widest signed range
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         limit_low_ff <= LIMIT_LOW_RST;
      end else if (s0_lim_low || s1_lim_low) begin
         limit_low_ff <= val_lim_low;
      end
   end

   // high counting limit
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         limit_high_ff <= LIMIT_HIGH_RST;
      end else if (s0_lim_high || s1_lim_high) begin
         limit_high_ff <= val_lim_high;
      end
   end

   // ==========================================
   // status: fault set wins over clear, so no failure is ever lost
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         load_fault_flag_ff <= 1'b0;
      end else if (fail_evt) begin
         load_fault_flag_ff <= 1'b1;
      end else if (i_fault_clear) begin
         load_fault_flag_ff <= 1'b0;
      end
   end

   // acks toggle on completion only; a refused load leaves them alone
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         first_load_done_toggle_ff <= 1'b0;
         second_load_done_toggle_ff <= 1'b0;
      end else begin
         if (ok0) first_load_done_toggle_ff <= ~first_load_done_toggle_ff;
         if (ok1) second_load_done_toggle_ff <= ~second_load_done_toggle_ff;
      end
   end

   // ==========================================
   // enables follow byte 9 at each commit; both sync enables also need i_incr_encoder
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         capture_enable_ff <= 1'b0;
         sync_downward_enable_ff <= 1'b0;
         sync_upward_enable_ff <= 1'b0;
      end else if (i_image_commit) begin
         capture_enable_ff <= enables[EN_CAPTURE_BIT];
         sync_downward_enable_ff <= enables[SYNC_DOWN_BIT] && i_incr_encoder;
         sync_upward_enable_ff <= enables[EN_SYNC_UP_BIT] && i_incr_encoder;
      end
   end

   // ==========================================
   // outputs straight from flip-flops
   assign o_capture_enable = capture_enable_ff;
   assign o_sync_downward_enable = sync_downward_enable_ff;
   assign o_sync_upward_enable = sync_upward_enable_ff;
   assign o_count_load = count_load_ff;
   assign o_count_load_value = count_load_value_ff;
   assign o_start_value = start_value_ff;
   assign o_compare0_value = compare0_ff;
   assign o_compare1_value = compare1_ff;
   assign o_limit_low_value = limit_low_ff;
   assign o_limit_high_value = limit_high_ff;
   assign o_feedback_byte12 = {5'h00, load_fault_flag_ff, 2'h0};
   assign o_feedback_byte13 = {4'h0, second_load_done_toggle_ff,
      first_load_done_toggle_ff, 2'h0};
endmodule

// >>> core/ld_ctrl_pkg.sv
// constants for the per-channel load control interface
// assumes a byte-wide cyclic output image written by the controller
package ld_ctrl_pkg;
   // ==========================================
   // control image byte offsets
   localparam logic [3:0] OFS_FIRST_VALUE = 4'h0;
   localparam logic [3:0] OFS_SECOND_VALUE = 4'h4;
   localparam logic [3:0] OFS_SELECTORS = 4'h8;
   localparam logic [3:0] OFS_ENABLES = 4'h9;
   localparam logic [3:0] OFS_LAST = 4'hb;
   // ==========================================
   // field positions
   localparam int SEL0_LSB = 0;
   localparam int SEL1_LSB = 4;
   localparam int EN_CAPTURE_BIT = 7;
   localparam int SYNC_DOWN_BIT = 6;
   localparam int EN_SYNC_UP_BIT = 5;
   localparam int FB12_FAULT_BIT = 2;
   localparam int FB13_ACK0_BIT = 2;
   localparam int FB13_ACK1_BIT = 3;
   // ==========================================
   // reset values
   localparam logic [31:0] VALUE_RST = 32'h0000_0000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [31:0] LIMIT_HIGH_RST = 32'h7fff_ffff;
   localparam logic [31:0] LIMIT_LOW_RST = 32'h8000_0000;
   // ==========================================
   // selector codes
   typedef enum logic [3:0] {
      SEL_IDLE = 4'b0000,
      SEL_COUNT = 4'b0001,
      SEL_RSVD2 = 4'b0010,
      SEL_START = 4'b0011,
      SEL_CMP0 = 4'b0100,
      SEL_CMP1 = 4'b0101,
      SEL_LIM_LOW = 4'b0110,
      SEL_LIM_HIGH = 4'b0111
   } sel_code_t;
   // target index of a decoded load
   typedef enum logic [2:0] {
      TGT_NONE = 3'b000,
      TGT_COUNT = 3'b001,
      TGT_START = 3'b010,
      TGT_CMP0 = 3'b011,
      TGT_CMP1 = 3'b100,
      TGT_LIM_LOW = 3'b101,
      TGT_LIM_HIGH = 3'b110
   } tgt_t;
endpackage

// >>> core/sel_decode.sv
// decoder for one 4-bit load meaning selector
// assumes the selector is a registered control field on i_mclk
`timescale 1ns/1ps
module sel_decode
   import ld_ctrl_pkg::*;
(
   input wire logic [3:0] i_sel,
   output ld_ctrl_pkg::tgt_t o_tgt,
   output logic o_reserved
);
   // ==========================================
   // code to target mapping
   always_comb begin
      o_tgt = TGT_NONE;
      o_reserved = 1'b0;
      case (i_sel)
         SEL_IDLE: o_tgt = TGT_NONE;
         SEL_COUNT: o_tgt = TGT_COUNT;
         SEL_START: o_tgt = TGT_START;
         SEL_CMP0: o_tgt = TGT_CMP0;
         SEL_CMP1: o_tgt = TGT_CMP1;
         SEL_LIM_LOW: o_tgt = TGT_LIM_LOW;
         SEL_LIM_HIGH: o_tgt = TGT_LIM_HIGH;
         default: o_reserved = 1'b1; // 0010 and 1xxx load nothing
      endcase
   end
endmodule

// >>> bench/ld_ctrl_host.sv
// controller-side model: writes the control image byte by byte
// assumes the block samples strobe and commit on the rising i_mclk
`timescale 1ns/1ps
module ld_ctrl_host (
   input wire logic i_mclk,
   output logic o_wr_en = 1'b0,
   output logic [3:0] o_wr_addr = 4'h0,
   output logic [7:0] o_wr_data = 8'h00,
   output logic o_commit = 1'b0
);
   // ==========================================
   // one byte per strobe; data flips once released so nothing stale looks valid
   task automatic put(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      o_wr_en <= 1'b1;
      o_wr_addr <= a;
      o_wr_data <= d;
      @(posedge i_mclk);
      o_wr_en <= 1'b0;
      o_wr_data <= ~d;
   endtask
   // slot value, least significant byte first
   task automatic word(input logic [3:0] a, input logic [31:0] v);
      for (int i = 0; i < 4; i++) begin
         put(a + 4'(i), v[8*i +: 8]);
      end
   endtask
   // end of controller cycle
   task automatic commit();
      @(posedge i_mclk);
      o_commit <= 1'b1;
      @(posedge i_mclk);
      o_commit <= 1'b0;
   endtask
endmodule

// >>> bench/ld_ctrl_chk.sv
// checker for the load control block, watching its ports only
// assumes a single i_mclk domain with synchronous i_reset
`timescale 1ns/1ps
module ld_ctrl_chk (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_image_commit,
   input wire logic i_incr_encoder,
   input wire logic i_fault_clear,
   input wire logic o_capture_enable,
   input wire logic o_count_load,
   input wire logic [31:0] o_start_value,
   input wire logic [31:0] o_compare0_value,
   input wire logic [31:0] o_limit_low_value,
   input wire logic [7:0] o_feedback_byte12,
   input wire logic [7:0] o_feedback_byte13
);
   // ==========================================
   // no start, compare 0 or low limit value moves and no count load pulse is high except one cycle after a commit; the fault flag falls one cycle after i_fault_clear
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   count_load_a: assert property (o_count_load |-> $past(i_image_commit && i_incr_encoder))
      else $error("count load without commit");
   start_load_a: assert property ($changed(o_start_value) |-> $past(i_image_commit && i_incr_encoder))
      else $error("start value moved");
   cmp_load_a: assert property ($changed(o_compare0_value) |-> $past(i_image_commit))
      else $error("compare value moved");
   limit_load_a: assert property ($changed(o_limit_low_value) |-> $past(i_image_commit && i_incr_encoder))
      else $error("limit moved");
   capture_en_a: assert property ($changed(o_capture_enable) |-> $past(i_image_commit))
      else $error("capture enable moved");
   ack_toggle_a: assert property ($changed(o_feedback_byte13) |-> $past(i_image_commit))
      else $error("ack toggled without commit");
   fault_set_a: assert property ($rose(o_feedback_byte12[2]) |-> $past(i_image_commit))
      else $error("fault set without commit");
   fault_clear_a: assert property ($fell(o_feedback_byte12[2]) |-> $past(i_fault_clear))
      else $error("fault cleared unasked");
endmodule
bind counter_load_control_interface ld_ctrl_chk u_chk (.i_mclk, .i_reset, .i_image_commit,
   .i_incr_encoder, .i_fault_clear, .o_capture_enable, .o_count_load, .o_start_value,
   .o_compare0_value, .o_limit_low_value, .o_feedback_byte12, .o_feedback_byte13);

// >>> bench/counter_load_control_interface_bench.sv
// self-checking bench for the load control block
// assumes ld_ctrl_host drives the write port and the checker is bound
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module counter_load_control_interface_bench;
   import ld_ctrl_pkg::*;
   logic i_mclk = 0, i_reset = 1, i_incr_encoder = 1, i_fault_clear = 0;
   logic i_wr_en, i_image_commit, cap, dn, up, o_count_load;
   logic [3:0] i_wr_addr, t;
   logic [7:0] i_wr_data, fb12, fb13;
   logic [31:0] cnt, st, c0, c1, lo, hi, v;
   logic [3:0] cs [6] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
   int n_mismatch = 0, check_count = 0;
   ld_ctrl_host h (.i_mclk, .o_wr_en(i_wr_en), .o_wr_addr(i_wr_addr), .o_wr_data(i_wr_data),
      .o_commit(i_image_commit));
   counter_load_control_interface DUT (.i_mclk, .i_reset, .i_wr_en, .i_wr_addr, .i_wr_data,
      .i_image_commit, .i_incr_encoder, .i_fault_clear, .o_capture_enable(cap),
      .o_sync_downward_enable(dn), .o_sync_upward_enable(up), .o_count_load,
      .o_count_load_value(cnt), .o_start_value(st), .o_compare0_value(c0),
      .o_compare1_value(c1), .o_limit_low_value(lo), .o_limit_high_value(hi),
      .o_feedback_byte12(fb12), .o_feedback_byte13(fb13));
   // ==========================================
   // helpers
   initial begin
      forever #25 i_mclk = ~i_mclk;
   end
   function automatic logic [31:0] tv(input logic [3:0] c);
      case (c)
         4'h1: tv = cnt;
         4'h3: tv = st;
         4'h4: tv = c0;
         4'h5: tv = c1;
         4'h6: tv = lo;
         default: tv = hi;
      endcase
   endfunction
   // selector byte then commit; outputs read just after the answering edge
   task automatic ld(input logic [3:0] a, input logic [7:0] s);
      h.put(a, s);
      h.commit();
      #1;
   endtask
   task automatic report_and_stop();
      if (n_mismatch == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge i_mclk);
      n_mismatch++;
      report_and_stop();
   end
   // ==========================================
   // scenarios
   initial begin
      t = 4'h0;
      repeat (4) @(posedge i_mclk);
      i_reset <= 1'b0;
      // every load code through slot 0, ack toggles each time
      foreach (cs[k]) begin
         v = 32'h8765_4300 + 32'(k);
         h.word(4'h0, v);
         ld(4'h8, {4'h0, cs[k]});
         `CHK("target", v, tv(cs[k]))
         `CHK("count pulse", cs[k] == 4'h1, o_count_load)
         t[0] = ~t[0];
         `CHK("ack", {2'b00, t, 2'b00}, fb13)
         ld(4'h8, 8'h00);
      end
      // both slots at once, slot 1 in the upper nibble
      h.word(4'h4, 32'h0bad_cafe);
      ld(4'h8, 8'h54);
      `CHK("slot1", 32'h0bad_cafe, c1)
      t = t ^ 4'h3;
      `CHK("both acks", {2'b00, t, 2'b00}, fb13)
      // reserved codes, deliberately sent, even codes in slot 0, odd codes in slot 1
      for (int c = 2; c < 16; c++) begin
         if (c > 2 && c < 8) continue;
         @(posedge i_mclk) i_fault_clear <= 1'b1;
         @(posedge i_mclk) i_fault_clear <= 1'b0;
         #1;
         `CHK("cleared", 8'h00, fb12)
         ld(4'h8, c[0] ? {c[3:0], 4'h0} : {4'h0, c[3:0]});
         `CHK("fault", 8'h04, fb12)
         `CHK("no ack", {2'b00, t, 2'b00}, fb13)
         ld(4'h8, 8'h00);
      end
      // encoder-only load refused without an encoder
      @(posedge i_mclk) i_incr_encoder <= 1'b0;
      ld(4'h8, 8'h07);
      `CHK("no limit", 32'h8765_4305, hi)
      `CHK("enc fault", 8'h04, fb12)
      ld(4'h9, 8'he0);
      `CHK("enables", 3'b100, {cap, dn, up})
      @(posedge i_mclk) i_incr_encoder <= 1'b1;
      ld(4'h9, 8'h40);
      `CHK("down", 3'b010, {cap, dn, up})
      ld(4'h9, 8'h20);
      `CHK("up", 3'b001, {cap, dn, up})
      // second reset in mid-run
      @(posedge i_mclk) i_reset <= 1'b1;
      repeat (4) @(posedge i_mclk);
      i_reset <= 1'b0;
      @(posedge i_mclk);
      #1;
      `CHK("rst lim", {LIMIT_LOW_RST, LIMIT_HIGH_RST}, {lo, hi})
      `CHK("rst fb", 16'h0000, {fb12, fb13})
      report_and_stop();
   end
endmodule
